// file: rtl/svw_pkg.sv
`default_nettype none
package svw_pkg;
   // core clock and derived timing
   localparam longint CLK_HZ          = 64'd100_000_000;
   localparam longint HOLD_TIME_MS    = 64'd100;  // power-up / reset hold
   localparam longint WD_STEP_MS      = 64'd100;  // watchdog step
   localparam longint DEBOUNCE_US     = 64'd1000; // manual reset filter
   localparam longint CAL_WAVE_HZ     = 64'd512;
   // least times round up
   localparam longint HOLD_CYCLES_L   =
      (CLK_HZ * HOLD_TIME_MS + 64'd999) / 64'd1000;
   localparam longint WD_STEP_CYCLES_L =
      (CLK_HZ * WD_STEP_MS + 64'd999) / 64'd1000;
   localparam longint DEBOUNCE_CYCLES_L =
      (CLK_HZ * DEBOUNCE_US + 64'd999_999) / 64'd1_000_000;
   // half period of the square wave, rounded down
   localparam longint CAL_HALF_CYCLES_L = CLK_HZ / (CAL_WAVE_HZ * 64'd2);
   localparam int unsigned HOLD_CYCLES      = int'(HOLD_CYCLES_L);
   localparam int unsigned WD_STEP_CYCLES   = int'(WD_STEP_CYCLES_L);
   localparam int unsigned DEBOUNCE_CYCLES  = int'(DEBOUNCE_CYCLES_L);
   localparam int unsigned CAL_HALF_CYCLES  = int'(CAL_HALF_CYCLES_L);

   // register offsets
   localparam logic [7:0] REG_CAL_CTRL   = 8'h00;
   localparam logic [7:0] REG_FLAGS      = 8'h09;
   localparam logic [7:0] REG_WD_CTRL    = 8'h0a;
   localparam logic [7:0] REG_SUPPLY_CFG = 8'h0b;
   localparam logic [7:0] REG_CNT_CTRL   = 8'h0c;
   localparam logic [7:0] REG_EVENT_INPUT_ONE_LO    = 8'h0d;
   localparam logic [7:0] REG_EVENT_INPUT_ONE_HI    = 8'h0e;
   localparam logic [7:0] REG_EVENT_INPUT_TWO_LO    = 8'h0f;
   localparam logic [7:0] REG_EVENT_INPUT_TWO_HI    = 8'h10;
   localparam logic [7:0] REG_SERIAL_0   = 8'h11;
   localparam logic [7:0] REG_SERIAL_7   = 8'h18;

   // field positions
   localparam int CAL_MODE_BIT   = 2;
   localparam int POR_FLAG_BIT   = 6;
   localparam int WD_FLAG_BIT    = 7;
   localparam int WD_FAULT_EN    = 7;
   localparam int WD_TIMEOUT_W   = 5;
   localparam int LOCK_BIT       = 7;
   localparam int TRIP_W         = 2;
   localparam int EDGE_ONE_BIT   = 0;
   localparam int EDGE_TWO_BIT   = 1;
   localparam int CHAIN_BIT      = 2;
   localparam int SNAP_BIT       = 3;

   localparam logic [3:0] WD_RESTART_PATTERN = 4'ha;
   localparam logic [WD_TIMEOUT_W-1:0] WD_STOPPED = 5'h1f;
   localparam logic [WD_TIMEOUT_W-1:0] WD_TIMEOUT_MAXRUN = 5'h1d;

   // reset values of the stored settings
   localparam logic [WD_TIMEOUT_W-1:0] WD_TIMEOUT_RST = 5'h1f;
   localparam logic [TRIP_W-1:0]       TRIP_RST       = 2'h0;
   localparam logic [3:0]              CNT_CTRL_RST   = 4'h0;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } svw_reg_req_t;

   typedef struct packed {
      logic rstIn;   // level seen on the reset line
      logic rstOut;  // level driven when enabled
      logic rstOe;   // high while pulling the line low
   } svw_rst_pin_t;
endpackage : svw_pkg
`default_nettype wire

// file: rtl/svw_supervisor.sv
// Functional notes
// [R01] Pull reset line low while supply below trip, release after hold.
// [R02] Hold reset low at least 100 ms after supply recovers.
// [R03] Ignore register traffic while reset asserted; started writes complete.
// [R04] Trip field bits 1:0 of 0Bh choose one of four thresholds.
// [R05] Five-bit timeout gives 100 ms to 3 s in 100 ms steps.
// [R06] Watchdog drives reset only when fault enable set and timer expired.
// [R07] Watchdog restarts on the rising edge ending any reset pulse.
// [R08] With enable clear, expiry only sets the watchdog fault flag.
// [R09] Timeout all ones stops the watchdog counter.
// [R10] Writing 1010b to 09h low nibble restarts watchdog, loads timeout.
// [R11] Watchdog held disabled while supply below trip.
// [R12] Register 0Ah holds timeout in bits 4:0, fault enable bit 7.
// [R13] External low on reset line is debounced, then driven low 100 ms.
// [R14] Supply flag bit 6, watchdog flag bit 7 of 09h; software clears.
// [R15] Shared output low while sense input below reference.
// [R16] Calibration bit drives 512 Hz square wave, comparator ignored.
// [R17] Each event input increments its own 16-bit counter on chosen edge.
// [R18] Snapshot bit copies all four counter bytes into stable read copies.
// [R19] Counters writable; counting suppressed during such a write.
// [R20] Chain bit makes one 32-bit counter driven by input one only.
// [R21] Edge selects at bits 0 and 1; set them before presetting.
// [R22] Serial bytes 11h-18h writable until lock set; lock is permanent.
// [R23] Reset source flag cleared only by software writing zero.
// [R24] Event inputs synchronised, edges detected, one increment per edge.
`default_nettype none
module svw_supervisor
   import svw_pkg::*;
#(
   parameter int unsigned HOLD_CYC     = svw_pkg::HOLD_CYCLES,
   parameter int unsigned WD_STEP_CYC  = svw_pkg::WD_STEP_CYCLES,
   parameter int unsigned DEBOUNCE_CYC = svw_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned CAL_HALF_CYC = svw_pkg::CAL_HALF_CYCLES
)
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // analog front end results
   input  wire logic [3:0]            supplyBelowLevel,
   input  wire logic                  powerFailSenseLow,
   // register access
   input  wire svw_pkg::svw_reg_req_t regReq,
   output logic [7:0]                 regRdData,
   output logic                       regLocked,
   // reset line
   input  wire logic                  rstLineIn,
   output svw_pkg::svw_rst_pin_t      rstLine,
   // event inputs
   input  wire logic                  eventInputOne,
   input  wire logic                  eventInputTwo,
   // shared fail / calibration output
   output logic                       calOrFailOut
);
   import svw_pkg::*;

   if (HOLD_CYC < 1 || WD_STEP_CYC < 1 || DEBOUNCE_CYC < 1 ||
       CAL_HALF_CYC < 1)
   begin : gCheck
      $error("svw_supervisor: timing counts must be at least one");
   end

   // register state
   logic                    calMode_q;
   logic                    porFlag_q;
   logic                    wdFlag_q;
   logic [WD_TIMEOUT_W-1:0] wdTimeout_q;
   logic                    wdFaultEn_q;
   logic [TRIP_W-1:0]       tripSel_q;
   logic                    serialLock_q;
   logic [3:0]              cntCtrl_q;
   logic [7:0]              serial_q [8];
   logic [31:0]             count_q;
   logic [31:0]             snap_q;

   // reset line state
   logic        supplyLow;
   logic [31:0] holdCnt_q;
   logic [31:0] debCnt_q;
   logic        rstDrive;
   logic        rstDrivePrev_q;
   logic        wdExpire;
   logic        wdTrip;
   logic        manualTrip;

   // watchdog state
   logic [31:0]             wdPre_q;
   logic [WD_TIMEOUT_W-1:0] wdSteps_q;
   logic [WD_TIMEOUT_W-1:0] wdLoad_q;
   logic                    wdRestart;

   // write decode, refused while reset is driven
   logic wrOk;
   logic wrFlags;
   logic wrCntByte;
   assign wrOk      = regReq.wr && !rstDrive; // R03
   assign wrFlags   = wrOk && regReq.addr == REG_FLAGS;
   assign wrCntByte = wrOk && regReq.addr >= REG_EVENT_INPUT_ONE_LO &&
                      regReq.addr <= REG_EVENT_INPUT_TWO_HI;
   assign regLocked = rstDrive; // R03

   assign supplyLow = supplyBelowLevel[tripSel_q]; // R04

   // reset line driver
   assign rstDrive = supplyLow || holdCnt_q != 32'h0; // R01
   assign rstLine.rstOut = 1'b0;
   assign rstLine.rstOe  = rstDrive;
   assign rstLine.rstIn  = rstLineIn;

   // watchdog drives reset only when enabled
   assign wdTrip = wdExpire && wdFaultEn_q; // R06

   // the hold counter reloads while supply is low, so the full hold
   // always follows recovery, whatever the trigger was
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         holdCnt_q <= HOLD_CYC;
      else if (supplyLow || wdTrip || manualTrip)
         holdCnt_q <= HOLD_CYC; // R02 R13
      else if (holdCnt_q != 32'h0)
         holdCnt_q <= holdCnt_q - 32'h1; // R01
   end

   // manual reset filter: only an external low while not driving counts
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         debCnt_q <= 32'h0;
      else if (rstDrive || rstLineIn)
         debCnt_q <= 32'h0;
      else if (debCnt_q != DEBOUNCE_CYC)
         debCnt_q <= debCnt_q + 32'h1; // R13
   end
   assign manualTrip = debCnt_q == DEBOUNCE_CYC - 1 && !rstLineIn &&
                       !rstDrive; // R13

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rstDrivePrev_q <= 1'b1;
      else
         rstDrivePrev_q <= rstDrive;
   end

   // restart on release of reset or on the pattern
   assign wdRestart = (rstDrivePrev_q && !rstDrive) || // R07
      (wrFlags && regReq.data[3:0] == WD_RESTART_PATTERN); // R10

   // watchdog: prescaler of one step, then step counter; held through any
   // reset pulse, else a timeout shorter than the hold retriggers it forever
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wdPre_q   <= 32'h0;
         wdSteps_q <= '0;
         wdLoad_q  <= WD_TIMEOUT_RST;
      end
      else if (wdRestart)
      begin
         wdPre_q   <= 32'h0;
         wdSteps_q <= '0;
         wdLoad_q  <= wdTimeout_q; // R10
      end
      else if (supplyLow || rstDrive || wdLoad_q == WD_STOPPED)
      begin
         wdPre_q   <= 32'h0; // R09 R11
         wdSteps_q <= '0;
      end
      else if (wdExpire)
      begin
         wdPre_q   <= 32'h0; // free running: starts a new period
         wdSteps_q <= '0;
      end
      else if (wdPre_q == WD_STEP_CYC - 1)
      begin
         wdPre_q   <= 32'h0;
         wdSteps_q <= wdSteps_q + 5'h1; // R05
      end
      else
         wdPre_q <= wdPre_q + 32'h1;
   end
   // field n gives n+1 steps; codes above the 3 s point other than all ones stay at 3 s
   assign wdExpire = !supplyLow && !rstDrive && wdLoad_q != WD_STOPPED &&
      wdPre_q == WD_STEP_CYC - 1 &&
      wdSteps_q == ((wdLoad_q > WD_TIMEOUT_MAXRUN) ?
                    WD_TIMEOUT_MAXRUN : wdLoad_q); // R05 R11

   // reset source flags: set wins over a software clear
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         porFlag_q <= 1'b0;
         wdFlag_q  <= 1'b0;
      end
      else
      begin
         if (supplyLow)
            porFlag_q <= 1'b1; // R14
         else if (wrFlags && !regReq.data[POR_FLAG_BIT])
            porFlag_q <= 1'b0; // R23
         if (wdExpire)
            wdFlag_q <= 1'b1; // R08 R14
         else if (wrFlags && !regReq.data[WD_FLAG_BIT])
            wdFlag_q <= 1'b0; // R23
      end
   end

   // control registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         calMode_q    <= 1'b0;
         wdTimeout_q  <= WD_TIMEOUT_RST;
         wdFaultEn_q  <= 1'b0;
         tripSel_q    <= TRIP_RST;
         serialLock_q <= 1'b0;
         cntCtrl_q    <= CNT_CTRL_RST;
      end
      else if (wrOk)
      begin
         unique case (regReq.addr)
            REG_CAL_CTRL:
               calMode_q <= regReq.data[CAL_MODE_BIT];
            REG_WD_CTRL:
            begin
               wdTimeout_q <= regReq.data[WD_TIMEOUT_W-1:0]; // R12
               wdFaultEn_q <= regReq.data[WD_FAULT_EN]; // R12
            end
            REG_SUPPLY_CFG:
            begin
               tripSel_q <= regReq.data[TRIP_W-1:0]; // R04
               if (regReq.data[LOCK_BIT])
                  serialLock_q <= 1'b1; // R22
            end
            REG_CNT_CTRL:
               cntCtrl_q <= regReq.data[3:0]; // R21
            default:
               ;
         endcase
      end
   end

   // serial number bytes
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         serial_q <= '{default: 8'h00};
      else if (wrOk && !serialLock_q && regReq.addr >= REG_SERIAL_0 &&
               regReq.addr <= REG_SERIAL_7)
         serial_q[3'(regReq.addr - REG_SERIAL_0)] <= regReq.data; // R22
   end

   // event inputs: two-stage synchroniser, then edge detect
   logic [1:0] evMeta_q;
   logic [1:0] evSync_q;
   logic [1:0] evPrev_q;
   logic [1:0] evEdge;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         evMeta_q <= 2'h0;
         evSync_q <= 2'h0;
         evPrev_q <= 2'h0;
      end
      else
      begin
         evMeta_q <= {eventInputTwo, eventInputOne}; // R24
         evSync_q <= evMeta_q;
         evPrev_q <= evSync_q;
      end
   end
   // select bit high counts rising edges, low counts falling edges
   assign evEdge[0] = cntCtrl_q[EDGE_ONE_BIT] ?
      (evSync_q[0] && !evPrev_q[0]) : (!evSync_q[0] && evPrev_q[0]); // R17
   assign evEdge[1] = cntCtrl_q[EDGE_TWO_BIT] ?
      (evSync_q[1] && !evPrev_q[1]) : (!evSync_q[1] && evPrev_q[1]); // R17

   // counters; a write to any counter byte drops that cycle's edges
   logic [31:0] countInc;
   always_comb
   begin
      countInc = count_q;
      if (cntCtrl_q[CHAIN_BIT])
      begin
         if (evEdge[0])
            countInc = count_q + 32'h1; // R20
      end
      else
      begin
         if (evEdge[0])
            countInc[15:0] = count_q[15:0] + 16'h1; // R17
         if (evEdge[1])
            countInc[31:16] = count_q[31:16] + 16'h1; // R17
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         count_q <= 32'h0;
      else if (wrCntByte) // R19
      begin
         unique case (regReq.addr)
            REG_EVENT_INPUT_ONE_LO: count_q[7:0]   <= regReq.data;
            REG_EVENT_INPUT_ONE_HI: count_q[15:8]  <= regReq.data;
            REG_EVENT_INPUT_TWO_LO: count_q[23:16] <= regReq.data;
            REG_EVENT_INPUT_TWO_HI: count_q[31:24] <= regReq.data;
            default:     count_q        <= count_q;
         endcase
      end
      else
         count_q <= countInc;
   end

   // snapshot of all four bytes; reads come from the copy only
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         snap_q <= 32'h0;
      else if (wrOk && regReq.addr == REG_CNT_CTRL &&
               regReq.data[SNAP_BIT])
         snap_q <= count_q; // R18
   end

   // square wave and shared output
   logic [31:0] calDiv_q;
   logic        calWave_q;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         calDiv_q  <= 32'h0;
         calWave_q <= 1'b0;
      end
      else if (!calMode_q)
      begin
         calDiv_q  <= 32'h0;
         calWave_q <= 1'b0;
      end
      else if (calDiv_q == CAL_HALF_CYC - 1)
      begin
         calDiv_q  <= 32'h0;
         calWave_q <= !calWave_q; // R16
      end
      else
         calDiv_q <= calDiv_q + 32'h1;
   end

   // hysteresis on a rising sense input lives in the analog comparator
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         calOrFailOut <= 1'b1;
      else if (calMode_q)
         calOrFailOut <= calWave_q; // R16
      else
         calOrFailOut <= !powerFailSenseLow; // R15
   end

   // read data, one cycle after the address; unmapped reads zero
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         regRdData <= 8'h00;
      else if (rstDrive)
         regRdData <= 8'h00; // R03
      else if (regReq.addr >= REG_SERIAL_0 && regReq.addr <= REG_SERIAL_7)
         regRdData <= serial_q[3'(regReq.addr - REG_SERIAL_0)]; // R22
      else
      begin
         unique case (regReq.addr)
            REG_CAL_CTRL:
               regRdData <= 8'(calMode_q) << CAL_MODE_BIT;
            REG_FLAGS:
               regRdData <= (8'(wdFlag_q) << WD_FLAG_BIT) |
                            (8'(porFlag_q) << POR_FLAG_BIT); // R14
            REG_WD_CTRL:
               regRdData <= (8'(wdFaultEn_q) << WD_FAULT_EN) |
                            8'(wdTimeout_q); // R12
            REG_SUPPLY_CFG:
               regRdData <= (8'(serialLock_q) << LOCK_BIT) |
                            8'(tripSel_q);
            REG_CNT_CTRL: regRdData <= 8'(cntCtrl_q);
            REG_EVENT_INPUT_ONE_LO:  regRdData <= snap_q[7:0];
            REG_EVENT_INPUT_ONE_HI:  regRdData <= snap_q[15:8];
            REG_EVENT_INPUT_TWO_LO:  regRdData <= snap_q[23:16];
            REG_EVENT_INPUT_TWO_HI:  regRdData <= snap_q[31:24];
            default:      regRdData <= 8'h00;
         endcase
      end
   end
endmodule : svw_supervisor
`default_nettype wire

// file: testbench/svw_supervisor_monitor.sv
`default_nettype none
module svw_supervisor_monitor
   import svw_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 50
)
(
   // clock and reset
   input wire logic                  core_clk,
   input wire logic                  rst,
   // watched ports
   input wire logic [3:0]            supplyBelowLevel,
   input wire logic                  powerFailSenseLow,
   input wire svw_pkg::svw_reg_req_t regReq,
   input wire logic [7:0]            regRdData,
   input wire logic                  regLocked,
   input wire logic                  rstLineIn,
   input wire svw_pkg::svw_rst_pin_t rstLine,
   input wire logic                  calOrFailOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        calMode_q;
   int unsigned runLen_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // the pin's duty depends on a register bit, so mirror accepted writes
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         calMode_q <= 1'b0;
      else if (regReq.wr && !rstLine.rstOe && regReq.addr == REG_CAL_CTRL)
         calMode_q <= regReq.data[CAL_MODE_BIT];
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         runLen_q <= 0;
      else
         runLen_q <= rstLine.rstOe ? runLen_q + 1 : 0;
   chk_supply_low_drive: assert property (
      supplyBelowLevel[0] |-> rstLine.rstOe)
      else $error("reset line idle at low supply");
   chk_hold_min_len: assert property (
      $fell(rstLine.rstOe) |-> runLen_q >= HOLD_CYC - 1)
      else $error("reset pulse shorter than hold time");
   chk_lock_follows: assert property (
      regLocked == rstLine.rstOe)
      else $error("register lock differs from reset line");
   chk_read_blank: assert property (
      rstLine.rstOe && $past(rstLine.rstOe) |-> regRdData == 8'h00)
      else $error("read data during reset");
   chk_fail_follows: assert property (
      !calMode_q && !$past(calMode_q)
      |-> calOrFailOut == !$past(powerFailSenseLow))
      else $error("fail output wrong");
   chk_cal_toggles: assert property (
      calMode_q && $past(calMode_q) |-> ##[1:6] $changed(calOrFailOut))
      else $error("calibration wave stuck");
   chk_manual_trip: assert property (
      (!rstLineIn && !rstLine.rstOe) [*5] |-> ##[0:2] rstLine.rstOe)
      else $error("manual reset not taken");
   chk_pin_echo: assert property (
      rstLine.rstIn == rstLineIn && !rstLine.rstOut)
      else $error("reset pin echo wrong");
endmodule : svw_supervisor_monitor
bind svw_supervisor svw_supervisor_monitor #(.HOLD_CYC(HOLD_CYC)) uMon (
   .core_clk(core_clk), .rst(rst), .supplyBelowLevel(supplyBelowLevel),
   .powerFailSenseLow(powerFailSenseLow), .regReq(regReq),
   .regRdData(regRdData), .regLocked(regLocked), .rstLineIn(rstLineIn),
   .rstLine(rstLine), .calOrFailOut(calOrFailOut));
`default_nettype wire

// file: testbench/svw_host_model.sv
`default_nettype none
module svw_host_model
(
   // reset wire parties
   input wire logic devPullLow,
   input wire logic pressBtn,
   output logic     lineLvl
);
   timeunit 1ns;
   timeprecision 1ps;
   // weak pull-up: any party pulling low wins the wire
   assign lineLvl = !(devPullLow || pressBtn);
endmodule : svw_host_model
`default_nettype wire

// file: testbench/tb_svw_supervisor.sv
`default_nettype none
module tb_svw_supervisor;
   import svw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned HOLD = 50;
   logic         core_clk = 1'b0;
   logic         rst = 1'b1;
   logic [3:0]   supplyBelowLevel = 4'h0;
   logic         powerFailSenseLow = 1'b0;
   svw_reg_req_t regReq = '0;
   logic [7:0]   regRdData;
   logic         regLocked;
   logic         lineLvl;
   svw_rst_pin_t rstLine;
   logic         eventInputOne = 1'b0;
   logic         eventInputTwo = 1'b0;
   logic         calOrFailOut;
   logic         pressBtn = 1'b0;
   logic         hit;
   int           bad_count = 0;
   int           tests_run = 0;
   int           waited;
   always #5 core_clk = ~core_clk;
   svw_supervisor #(.HOLD_CYC(HOLD), .WD_STEP_CYC(20), .DEBOUNCE_CYC(5),
      .CAL_HALF_CYC(4)) DUT (.core_clk(core_clk), .rst(rst),
      .supplyBelowLevel(supplyBelowLevel),
      .powerFailSenseLow(powerFailSenseLow), .regReq(regReq),
      .regRdData(regRdData), .regLocked(regLocked), .rstLineIn(lineLvl),
      .rstLine(rstLine), .eventInputOne(eventInputOne),
      .eventInputTwo(eventInputTwo), .calOrFailOut(calOrFailOut));
   svw_host_model uHost (.devPullLow(rstLine.rstOe), .pressBtn(pressBtn),
      .lineLvl(lineLvl));
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task automatic ck(input string nm, input logic [7:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : ck
   task automatic wr(input logic [7:0] a, d);
      @(negedge core_clk);
      regReq = '{1'b1, a, d};
      @(negedge core_clk);
      regReq.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, e, input string nm);
      @(negedge core_clk);
      regReq.addr = a;
      @(negedge core_clk);
      ck(nm, e, regRdData);
   endtask : rd
   task automatic wo(input logic v, input int n);
      waited = 0;
      while (rstLine.rstOe !== v && waited < n)
      begin
         @(negedge core_clk);
         waited++;
      end
      if (rstLine.rstOe !== v)
      begin
         $display("ERROR reset line level expected %b seen %b", v,
            rstLine.rstOe);
         bad_count++;
         test_done;
      end
   endtask : wo
   task automatic quiet(input int n);
      hit = 1'b0;
      repeat (n) @(negedge core_clk) hit |= rstLine.rstOe;
   endtask : quiet
   task automatic t_regs;
      rd(REG_FLAGS, 8'h00, "flags at reset");
      rd(REG_WD_CTRL, 8'h1f, "watchdog control at reset");
      rd(REG_SUPPLY_CFG, 8'h00, "supply config at reset");
      rd(REG_CNT_CTRL, 8'h00, "counter control at reset");
      rd(8'h05, 8'h00, "unmapped read");
   endtask : t_regs
   task automatic t_supply;
      for (int k = 0; k < 4; k++)
      begin
         wr(REG_SUPPLY_CFG, 8'(k));
         supplyBelowLevel = 4'hf << (k + 1);
         repeat (3) @(negedge core_clk);
         ck("trip above level", 8'h00, {7'h0, rstLine.rstOe});
         supplyBelowLevel = 4'hf << k;
         @(negedge core_clk);
         ck("trip at level", 8'h01, {7'h0, rstLine.rstOe});
         wr(REG_WD_CTRL, 8'h05);
         supplyBelowLevel = 4'h0;
         wo(1'b0, 200);
         ck("hold", 8'h01, {7'h0, waited inside {[HOLD:HOLD+2]}});
         rd(REG_WD_CTRL, 8'h1f, "write during reset");
         rd(REG_FLAGS, 8'h40, "supply flag");
         wr(REG_FLAGS, 8'hc0);
         rd(REG_FLAGS, 8'h40, "flag kept on write one");
         wr(REG_FLAGS, 8'h00);
         rd(REG_FLAGS, 8'h00, "flag cleared");
      end
   endtask : t_supply
   task automatic t_wdog;
      wr(REG_WD_CTRL, 8'h80);
      wr(REG_FLAGS, 8'h0a);
      wo(1'b1, 40);
      ck("wd period", 8'h01, {7'h0, waited inside {[18:22]}});
      wo(1'b0, 100);
      wo(1'b1, 40);
      ck("wd restart", 8'h01, {7'h0, waited >= 18 && waited <= 22});
      wo(1'b0, 100);
      wr(REG_WD_CTRL, 8'h02);
      wr(REG_FLAGS, 8'h0a);
      quiet(70);
      ck("wd quiet when off", 8'h00, {7'h0, hit});
      rd(REG_FLAGS, 8'h80, "wd flag");
      wr(REG_WD_CTRL, 8'h82);
      wr(REG_FLAGS, 8'h0a);
      hit = 1'b0;
      repeat (3)
      begin
         repeat (40) @(negedge core_clk) hit |= rstLine.rstOe;
         wr(REG_FLAGS, 8'h0a);
      end
      ck("kick holds off", 8'h00, {7'h0, hit});
      wr(REG_FLAGS, 8'h05);
      wo(1'b1, 80);
      wo(1'b0, 100);
      wr(REG_WD_CTRL, 8'h9f);
      wr(REG_FLAGS, 8'h0a);
      quiet(100);
      ck("wd stopped", 8'h00, {7'h0, hit});
      rd(REG_FLAGS, 8'h00, "no expiry when stopped");
   endtask : t_wdog
   task automatic t_manual;
      pressBtn = 1'b1;
      repeat (3) @(negedge core_clk);
      pressBtn = 1'b0;
      quiet(10);
      ck("glitch filtered", 8'h00, {7'h0, hit});
      pressBtn = 1'b1;
      repeat (8) @(negedge core_clk);
      pressBtn = 1'b0;
      ck("manual reset", 8'h01, {7'h0, rstLine.rstOe});
      wo(1'b0, 100);
   endtask : t_manual
   task automatic t_count;
      logic [7:0] pre [4] = '{8'hff, 8'hff, 8'h00, 8'h00};
      logic [7:0] exp [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
      wr(REG_CNT_CTRL, 8'h01);
      for (int i = 0; i < 4; i++)
         wr(8'(REG_EVENT_INPUT_ONE_LO + i), 8'h00);
      eventInputOne = 1'b1;
      eventInputTwo = 1'b1;
      repeat (5) @(negedge core_clk);
      wr(REG_CNT_CTRL, 8'h09);
      rd(REG_EVENT_INPUT_ONE_LO, 8'h01, "count one rise");
      rd(REG_EVENT_INPUT_TWO_LO, 8'h00, "count two rise");
      eventInputOne = 1'b0;
      eventInputTwo = 1'b0;
      repeat (5) @(negedge core_clk);
      wr(REG_CNT_CTRL, 8'h09);
      rd(REG_EVENT_INPUT_TWO_LO, 8'h01, "count two fall");
      eventInputOne = 1'b1;
      repeat (5) @(negedge core_clk);
      rd(REG_EVENT_INPUT_ONE_LO, 8'h01, "snapshot stable");
      wr(REG_CNT_CTRL, 8'h05);
      for (int i = 0; i < 4; i++)
         wr(8'(REG_EVENT_INPUT_ONE_LO + i), pre[i]);
      eventInputOne = 1'b0;
      eventInputTwo = 1'b1;
      repeat (5) @(negedge core_clk);
      eventInputOne = 1'b1;
      eventInputTwo = 1'b0;
      repeat (5) @(negedge core_clk);
      wr(REG_CNT_CTRL, 8'h0d);
      for (int i = 0; i < 4; i++)
         rd(8'(REG_EVENT_INPUT_ONE_LO + i), exp[i], "chained byte");
   endtask : t_count
   task automatic t_cal;
      int n;
      logic prev;
      powerFailSenseLow = 1'b1;
      repeat (3) @(negedge core_clk);
      ck("fail out low", 8'h00, {7'h0, calOrFailOut});
      wr(REG_CAL_CTRL, 8'h04);
      n = 0;
      prev = calOrFailOut;
      repeat (40) @(negedge core_clk)
      begin
         n += int'(calOrFailOut !== prev);
         prev = calOrFailOut;
      end
      ck("wave edges", 8'h01, {7'h0, n >= 9 && n <= 11});
      wr(REG_CAL_CTRL, 8'h00);
      powerFailSenseLow = 1'b0;
      repeat (3) @(negedge core_clk);
      ck("fail out high", 8'h01, {7'h0, calOrFailOut});
   endtask : t_cal
   task automatic t_serial;
      for (int i = 0; i < 8; i++)
         wr(8'(REG_SERIAL_0 + i), 8'(8'h30 + i));
      wr(REG_SUPPLY_CFG, 8'h80);
      for (int i = 0; i < 8; i++)
         wr(8'(REG_SERIAL_0 + i), 8'h00);
      wr(REG_SUPPLY_CFG, 8'h00);
      rd(REG_SUPPLY_CFG, 8'h80, "lock bit");
      for (int i = 0; i < 8; i++)
         rd(8'(REG_SERIAL_0 + i), 8'(8'h30 + i), "serial byte");
   endtask : t_serial
   initial
   begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      wo(1'b0, 200);
      t_regs();
      t_supply();
      t_wdog();
      t_manual();
      t_count();
      t_cal();
      // locking is permanent, so it goes last
      t_serial();
      test_done();
   end
endmodule : tb_svw_supervisor
`default_nettype wire
